// ### include/chip_select_pkg.sv
// constants shared by the chip-select option logic
package chip_select_pkg;

    // =========================================================
    // circuit count and clocking
    localparam int NUM_SEL          = 12;   // index 0 is the boot circuit
    localparam int CLK_PERIOD_NS    = 10;
    localparam int SLOW_HALF_NS     = 40;
    localparam int SLOW_HALF_CYCLES = SLOW_HALF_NS / CLK_PERIOD_NS;

    // =========================================================
    // option word field positions
    localparam int MODE_BIT  = 15;
    localparam int BYTE_HI   = 14;
    localparam int BYTE_LO   = 13;
    localparam int RW_HI     = 12;
    localparam int RW_LO     = 11;
    localparam int STROBE_TIMING_SEL_BIT  = 10;
    localparam int ACK_HI    = 9;
    localparam int ACK_LO    = 6;
    localparam int SPACE_HI  = 5;
    localparam int SPACE_LO  = 4;
    localparam int IPL_HI    = 3;
    localparam int IPL_LO    = 1;
    localparam int AUTOVECTOR_REQ_BIT  = 0;

    // base word: address bits 23..11 above a block-size code
    localparam int BASE_HI   = 15;
    localparam int BASE_LO   = 3;
    localparam int SIZE_HI   = 2;

    // =========================================================
    // field encodings
    localparam logic [1:0] BYTE_LOWER  = 2'h1;
    localparam logic [1:0] BYTE_UPPER  = 2'h2;
    localparam logic [1:0] RW_READ     = 2'h1;
    localparam logic [1:0] RW_WRITE    = 2'h2;
    localparam logic [1:0] SPACE_CPU   = 2'h0;
    localparam logic [1:0] SPACE_USER  = 2'h1;
    localparam logic [1:0] SPACE_SUPER = 2'h2;
    localparam logic [1:0] SPACE_BOTH  = 2'h3;
    localparam logic [3:0] ACK_FAST    = 4'hE;
    localparam logic [3:0] ACK_EXTERN  = 4'hF;
    localparam logic [3:0] BOOT_WAIT   = 4'hD;
    localparam logic [2:0] FC_CPU      = 3'h7;
    localparam logic [3:0] CPU_INT_ACK_OUT    = 4'hF;

    // =========================================================
    // reset values
    localparam logic [15:0] BOOT_OPT_RESET  = 16'h7B70;
    localparam logic [15:0] BOOT_BASE_RESET = 16'h0007;
    localparam logic [15:0] OPT_RESET       = 16'h0000;
    localparam logic [15:0] BASE_RESET      = 16'h0000;

    // =========================================================
    // register byte offsets
    localparam logic [7:0] OPT_OFFSET    = 8'h00;
    localparam logic [7:0] BASE_OFFSET   = 8'h40;
    localparam logic [7:0] STATUS_OFFSET = 8'h80;

endpackage

// ### logic/select_match.sv
// address, space, lane, direction and level match of one circuit
`timescale 1ns/100ps
module select_match
    import chip_select_pkg::*;
(
    input  wire logic [15:0] optWord,
    input  wire logic [15:0] baseWord,
    input  wire logic [23:0] addr,
    input  wire logic [2:0]  funcCode,
    input  wire logic        isRead,
    input  wire logic        upperLane,
    input  wire logic        lowerLane,
    output logic             hit
);

    // =========================================================
    // decode
    wire logic [1:0]  byteSel  = optWord[BYTE_HI:BYTE_LO];
    wire logic [1:0]  rwSel    = optWord[RW_HI:RW_LO];
    wire logic [1:0]  spaceSel = optWord[SPACE_HI:SPACE_LO];
    wire logic [2:0]  iplSel   = optWord[IPL_HI:IPL_LO];
    wire logic [2:0]  sizeCode = baseWord[SIZE_HI:0];
    wire logic        cpuSpace = (funcCode == FC_CPU);
    wire logic        iackCyc  = cpuSpace && (addr[19:16] == CPU_INT_ACK_OUT);
    wire logic [12:0] sizeMask;

    // 2K,8K,16K,64K,128K,256K,512K,1M
    assign sizeMask = (sizeCode == 3'h0) ? 13'h1FFF :
                      (sizeCode == 3'h1) ? 13'h1FFC :
                      (sizeCode == 3'h2) ? 13'h1FF8 :
                      (sizeCode == 3'h3) ? 13'h1FE0 :
                      (sizeCode == 3'h4) ? 13'h1FC0 :
                      (sizeCode == 3'h5) ? 13'h1F80 :
                      (sizeCode == 3'h6) ? 13'h1F00 : 13'h1E00;

    wire logic addrHit  = ((addr[23:11] ^ baseWord[BASE_HI:BASE_LO])
                          & sizeMask) == 13'h0000;            // [RULE16]
    wire logic laneHit  = (byteSel[1] && upperLane)
                       || (byteSel[0] && lowerLane);           // [RULE4]
    wire logic rwHit    = isRead ? rwSel[0] : rwSel[1];        // [RULE5]
    wire logic spaceHit = cpuSpace ? (spaceSel == SPACE_CPU)
                        : (spaceSel == SPACE_BOTH)
                       || (funcCode[2] && spaceSel == SPACE_SUPER)
                       || (!funcCode[2] && spaceSel == SPACE_USER);
    wire logic levelHit = !iackCyc || (addr[3:1] == iplSel);   // [RULE11]

    assign hit = addrHit && laneHit && rwHit && spaceHit && levelHit;

endmodule

// ### logic/cycle_terminator.sv
// ends a bus cycle by wait count, fast, slow-clock or external ack
`timescale 1ns/100ps
module cycle_terminator
    import chip_select_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    cycleActive,
    input  wire logic [NUM_SEL-1:0]      hitVec,
    input  wire logic [NUM_SEL-1:0][15:0] optVec,
    input  wire logic                    iackCycle,
    input  wire logic                    extAck,
    input  wire logic                    slowTick,
    output logic                         cycleDone,
    output logic                         autovectorReq,
    output logic                         doneSeen
);

    logic [3:0]  waitCount_reg;
    logic        done_reg;
    logic        seen_reg;
    logic        autovector_req_reg;
    logic [15:0] selOpt;
    logic        anyHit;

    // =========================================================
    // lowest index wins when circuits overlap
    always_comb
    begin
        selOpt = 16'h0000;
        anyHit = 1'b0;
        for (int i = NUM_SEL - 1; i >= 0; i--)
        begin
            if (hitVec[i])
            begin
                selOpt = optVec[i];
                anyHit = 1'b1;
            end
        end
    end

    wire logic [3:0] ackSel  = selOpt[ACK_HI:ACK_LO];
    wire logic       syncSel = selOpt[MODE_BIT];                 // [RULE2]
    wire logic       avecSel = selOpt[AUTOVECTOR_REQ_BIT] && iackCycle;    // [RULE12]
    wire logic       waitEnd = (ackSel == ACK_FAST)
                            || (ackSel != ACK_EXTERN
                                && waitCount_reg >= ackSel);     // [RULE7]
    // sync mode ignores the ack field entirely
    wire logic       ownEnd  = avecSel ? 1'b1                    // [RULE9]
                            : syncSel ? slowTick : waitEnd;      // [RULE3]
    wire logic       endNow  = extAck || (anyHit && ownEnd);     // [RULE8]
    wire logic       live    = cycleActive && !seen_reg;

    // =========================================================
    // cycle state
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            waitCount_reg <= 4'h0;
            done_reg      <= 1'b0;
            seen_reg      <= 1'b0;
            autovector_req_reg      <= 1'b0;
        end
        else if (!cycleActive)
        begin
            waitCount_reg <= 4'h0;
            done_reg      <= 1'b0;
            seen_reg      <= 1'b0;
            autovector_req_reg      <= 1'b0;
        end
        else
        begin
            done_reg <= live && endNow;
            seen_reg <= seen_reg || endNow;
            autovector_req_reg <= autovector_req_reg || (live && endNow && avecSel);
            if (waitCount_reg != 4'hF)
                waitCount_reg <= waitCount_reg + 4'h1;
        end
    end

    assign cycleDone     = done_reg;
    assign autovectorReq = autovector_req_reg;
    assign doneSeen      = seen_reg;

    // =========================================================
    // checks
    property p_sync_hold;
        @(posedge clk) disable iff (!resetn)
        (live && anyHit && syncSel && !avecSel && !slowTick && !extAck)
        |=> !done_reg;
    endproperty
    a_sync_hold: assert property (p_sync_hold) // [RULE3]
        else $error("sync cycle ended without slow clock edge");

    property p_ext_ack;
        @(posedge clk) disable iff (!resetn)
        (live && extAck) ##1 cycleActive |-> done_reg;
    endproperty
    a_ext_ack: assert property (p_ext_ack) // [RULE8]
        else $error("external ack did not end the cycle");

    property p_autovector;
        @(posedge clk) disable iff (!resetn)
        (live && anyHit && avecSel) ##1 cycleActive |-> done_reg && autovector_req_reg;
    endproperty
    a_autovector: assert property (p_autovector) // [RULE9]
        else $error("autovector cycle not fast terminated");

    property p_extern_wait;
        @(posedge clk) disable iff (!resetn)
        (live && anyHit && !syncSel && !avecSel && ackSel == ACK_EXTERN
         && !extAck) |=> !done_reg;
    endproperty
    a_extern_wait: assert property (p_extern_wait) // [RULE7]
        else $error("cycle ended internally in external-ack mode");

endmodule

// ### logic/chip_select_options.sv
// chip-select option logic with its register slave
`timescale 1ns/100ps
module chip_select_options
    import chip_select_pkg::*;

// Notes on behaviour
// [RULE1] - boot option word resets to thirteen wait states
// [RULE2] - mode bit zero is asynchronous, one follows the slow bus clock
// [RULE3] - in synchronous mode strobe and ack fields are ignored
// [RULE4] - byte field picks upper, lower, both or no lanes
// [RULE5] - direction field limits selection to reads, writes or both
// [RULE6] - strobe field picks address-strobe or data-strobe timing
// [RULE7] - ack field gives wait count or waits for external ack
// [RULE8] - external ack ends the cycle even before the wait count
// [RULE9] - autovector forces fast termination, ack field unused
// [RULE10] - software sets space field to match memory or interrupt cycles
// [RULE11] - interrupt cycles match only when level equals the level field
// [RULE12] - autovector bit answers pin interrupt ack cycles with autovector
// [RULE13] - software sets read-only for interrupt ack or autovector use
// [RULE14] - software should pick address-strobe timing for interrupt use
// [RULE15] - two byte-wide memories use twin circuits differing in lane
// [RULE16] - a circuit selects only inside its base and block range
// [RULE17] - boot circuit resets to base zero, one megabyte block
// [RULE18] - select drops at the end of the cycle it asserted in
(
    input  wire logic               clk,
    input  wire logic               resetn,
    // register slave
    input  wire logic [7:0]         avsAddress,
    input  wire logic               avsRead,
    input  wire logic               avsWrite,
    input  wire logic [31:0]        avsWriteData,
    input  wire logic [3:0]         avsByteEnable,
    output logic [31:0]             avsReadData,
    output logic                    avsWaitRequest,
    // processor bus cycle
    input  wire logic [23:0]        addr,
    input  wire logic [2:0]         funcCode,
    input  wire logic               isRead,
    input  wire logic               upperLane,
    input  wire logic               lowerLane,
    input  wire logic               addrStrobe,
    input  wire logic               dataStrobe,
    // external side
    input  wire logic [1:0]         cycleAckInN,
    output logic [1:0]              cycleAckOutN,
    output logic [1:0]              cycleAckOeN,
    output logic [NUM_SEL-1:0]      selectOutN,
    output logic                    bootSelectOutN,
    output logic                    autovectorReq,
    output logic                    slowBusClock,
    output logic                    cycleDone
);

    logic [NUM_SEL-1:0][15:0] opt_reg;
    logic [NUM_SEL-1:0][15:0] base_reg;
    logic [NUM_SEL-1:0]       hitVec;
    logic [NUM_SEL-1:0]       sel_reg;
    logic [NUM_SEL-1:0]       sel_next;
    logic [1:0]               ackMeta_reg;
    logic [1:0]               ackSync_reg;
    logic [1:0]               ackLate_reg;
    logic [1:0]               ackStable_reg;
    logic [2:0]               slowCount_reg;
    logic                     slowClk_reg;
    logic                     readAck_reg;
    logic [31:0]              readData_reg;
    logic                     doneSeen;

    // =========================================================
    // register decode
    wire logic [7:0] wordAddr  = {avsAddress[7:2], 2'b00};
    wire logic       optSpace  = wordAddr >= OPT_OFFSET
                              && wordAddr < BASE_OFFSET;
    wire logic       baseSpace = wordAddr >= BASE_OFFSET
                              && wordAddr < STATUS_OFFSET;
    wire logic [3:0] regIndex  = avsAddress[5:2];
    wire logic       indexOk   = regIndex < 4'(NUM_SEL);
    wire logic       optWrite  = avsWrite && optSpace && indexOk;
    wire logic       baseWrite = avsWrite && baseSpace && indexOk;
    wire logic [15:0] laneMask = {{8{avsByteEnable[1]}},
                                  {8{avsByteEnable[0]}}};
    wire logic [31:0] statusWord = {14'h0000, autovectorReq, cycleDone,
                                    4'h0, ~selectOutN};
    wire logic [31:0] readMux  =
        (optSpace && indexOk)  ? {16'h0000, opt_reg[regIndex]}  :
        (baseSpace && indexOk) ? {16'h0000, base_reg[regIndex]} :
        (wordAddr == STATUS_OFFSET) ? statusWord : 32'h0000_0000;

    // reads take one wait cycle, writes none
    assign avsWaitRequest = avsRead && !readAck_reg;
    assign avsReadData    = readData_reg;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            readAck_reg  <= 1'b0;
            readData_reg <= 32'h0000_0000;
        end
        else
        begin
            readAck_reg <= avsRead && !readAck_reg;
            if (avsRead && !readAck_reg)
                readData_reg <= readMux;
        end
    end

    // =========================================================
    // option and base registers, one pair per circuit
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SEL; gi++)
        begin : g_sel
            localparam logic [15:0] OPT_INIT  =
                (gi == 0) ? BOOT_OPT_RESET : OPT_RESET;
            localparam logic [15:0] BASE_INIT =
                (gi == 0) ? BOOT_BASE_RESET : BASE_RESET;
            wire logic thisSel = (regIndex == 4'(gi));

            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    opt_reg[gi]  <= OPT_INIT;                  // [RULE1]
                    base_reg[gi] <= BASE_INIT;                 // [RULE17]
                end
                else
                begin
                    if (optWrite && thisSel)
                        opt_reg[gi] <= (opt_reg[gi] & ~laneMask)
                                     | (avsWriteData[15:0] & laneMask);
                    if (baseWrite && thisSel)
                        base_reg[gi] <= (base_reg[gi] & ~laneMask)
                                      | (avsWriteData[15:0] & laneMask);
                end
            end

            select_match u_match
            (
                .optWord   (opt_reg[gi]),
                .baseWord  (base_reg[gi]),
                .addr      (addr),
                .funcCode  (funcCode),
                .isRead    (isRead),
                .upperLane (upperLane),
                .lowerLane (lowerLane),
                .hit       (hitVec[gi])
            );

            // sync mode always times from the address strobe
            wire logic useData = opt_reg[gi][STROBE_TIMING_SEL_BIT]
                              && !opt_reg[gi][MODE_BIT];       // [RULE3]
            wire logic strobeOk = useData ? dataStrobe
                                          : addrStrobe;        // [RULE6]
            // held off after termination until the strobe falls
            assign sel_next[gi] = hitVec[gi] && addrStrobe && strobeOk
                               && !doneSeen;                   // [RULE18]
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            sel_reg <= '0;
        else
            sel_reg <= sel_next;
    end

    assign selectOutN     = ~sel_reg;
    assign bootSelectOutN = ~sel_reg[0];

    // =========================================================
    // external ack pins: three stages, accepted when stages two
    // and three agree, so a single glitch sample is dropped
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ackMeta_reg   <= 2'h3;
            ackSync_reg   <= 2'h3;
            ackLate_reg   <= 2'h3;
            ackStable_reg <= 2'h3;
        end
        else
        begin
            ackMeta_reg <= cycleAckInN;
            ackSync_reg <= ackMeta_reg;
            ackLate_reg <= ackSync_reg;
            for (int b = 0; b < 2; b++)
                if (ackSync_reg[b] == ackLate_reg[b])
                    ackStable_reg[b] <= ackLate_reg[b];
        end
    end

    wire logic extAck = !(&ackStable_reg);

    // =========================================================
    // slow bus clock for synchronous peripherals
    wire logic slowFlip = (slowCount_reg == 3'(SLOW_HALF_CYCLES - 1));
    wire logic slowTick = slowFlip && slowClk_reg;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            slowCount_reg <= 3'h0;
            slowClk_reg   <= 1'b0;
        end
        else
        begin
            slowCount_reg <= slowFlip ? 3'h0 : slowCount_reg + 3'h1;
            if (slowFlip)
                slowClk_reg <= !slowClk_reg;
        end
    end

    assign slowBusClock = slowClk_reg;

    // =========================================================
    // cycle termination
    wire logic iackCycle = (funcCode == FC_CPU) && (addr[19:16] == CPU_INT_ACK_OUT);

    cycle_terminator u_term
    (
        .clk           (clk),
        .resetn        (resetn),
        .cycleActive   (addrStrobe),
        .hitVec        (hitVec),
        .optVec        (opt_reg),
        .iackCycle     (iackCycle),
        .extAck        (extAck),
        .slowTick      (slowTick),
        .cycleDone     (cycleDone),
        .autovectorReq (autovectorReq),
        .doneSeen      (doneSeen)
    );

    // both ack lines pulled low for the terminating cycle unless it ends by autovector
    assign cycleAckOutN = 2'b00;
    assign cycleAckOeN  = {2{!(cycleDone && !autovectorReq)}};

    // =========================================================
    // checks
    property p_boot_wait;
        @(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> opt_reg[0][ACK_HI:ACK_LO] == BOOT_WAIT;
    endproperty
    a_boot_wait: assert property (p_boot_wait) // [RULE1]
        else $error("boot option word not at thirteen wait states");

    property p_boot_base;
        @(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> base_reg[0] == BOOT_BASE_RESET;
    endproperty
    a_boot_base: assert property (p_boot_base) // [RULE17]
        else $error("boot base not zero with one megabyte block");

    property p_drop_at_end;
        @(posedge clk) disable iff (!resetn)
        (cycleDone && addrStrobe) |=> &selectOutN;
    endproperty
    a_drop_at_end: assert property (p_drop_at_end) // [RULE18]
        else $error("select still asserted after cycle end");

    property p_lane;
        @(posedge clk) disable iff (!resetn)
        (!opt_reg[1][BYTE_HI] && upperLane && !lowerLane) |=> selectOutN[1];
    endproperty
    a_lane: assert property (p_lane) // [RULE4]
        else $error("select one asserted on unselected lane");

    property p_direction;
        @(posedge clk) disable iff (!resetn)
        (opt_reg[1][RW_HI:RW_LO] == RW_READ && !isRead) |=> selectOutN[1];
    endproperty
    a_direction: assert property (p_direction) // [RULE5]
        else $error("read-only select one asserted on a write");

endmodule

// ### sim/ack_partner.sv
// external peripheral model that returns the cycle acknowledge
`timescale 1ns/100ps
module ack_partner
(
    input  wire logic       clk,
    input  wire logic       selN,
    input  wire logic       enable,
    input  wire logic [3:0] delay,
    output logic [1:0]      ackN
);
    // ==========================================================
    // acknowledge pins
    int cnt = 0;
    initial ackN = 2'h3;
    always @(posedge clk)
    begin
        cnt <= (selN | !enable) ? 0 : cnt + 1;
        // pull-ups: a released pin reads high, not its last value
        ackN <= (!selN && enable && cnt >= delay) ? 2'h0 : 2'h3;
    end
endmodule

// ### sim/chip_select_options_tb.sv
// self-checking bench for the chip-select option logic
`timescale 1ns/100ps
module chip_select_options_tb import chip_select_pkg::*;;
    logic              clk = 1'b0;
    logic              resetn = 1'b0;
    logic [7:0]        avsAddress = 8'h00;
    logic              avsRead = 1'b0;
    logic              avsWrite = 1'b0;
    logic [31:0]       avsWriteData = 32'h0;
    logic [3:0]        avsByteEnable = 4'h3;
    logic [31:0]       avsReadData;
    logic              avsWaitRequest;
    logic [23:0]       addr = 24'h0;
    logic [2:0]        funcCode = 3'h5;
    logic              isRead = 1'b1;
    logic              upperLane = 1'b1;
    logic              lowerLane = 1'b1;
    logic              addrStrobe = 1'b0;
    logic              dataStrobe = 1'b0;
    logic [1:0]        ackInN;
    logic [NUM_SEL-1:0] selN;
    logic              avReq;
    logic              cycleDone;
    logic              ackOn = 1'b0;
    logic [31:0]       q;
    logic              av;
    logic [1:0]        ackOutN;
    logic [1:0]        oeN;
    logic              bootN;
    logic              slow;
    int                bad_count = 0;
    int                compares = 0;
    int                cycles = 0;
    int                idx = 0;
    int                s;
    int                e;
    int                n;

    always #5 clk = ~clk;

    chip_select_options chip_select_options_i (.clk(clk), .resetn(resetn),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .addr(addr), .funcCode(funcCode), .isRead(isRead),
        .upperLane(upperLane), .lowerLane(lowerLane),
        .addrStrobe(addrStrobe), .dataStrobe(dataStrobe),
        .cycleAckInN(ackInN), .cycleAckOutN(ackOutN), .cycleAckOeN(oeN),
        .selectOutN(selN), .bootSelectOutN(bootN), .autovectorReq(avReq),
        .slowBusClock(slow), .cycleDone(cycleDone));

    ack_partner ack_partner_i (.clk(clk), .selN(selN[1]), .enable(ackOn),
        .delay(4'h2), .ackN(ackInN));

    // ==========================================================
    // tasks and expectations
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        compares++;
        if (g !== x)
        begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", nm, x, g);
        end
    endtask

    // the request stands until waitrequest is sampled low at a rising edge
    task automatic bus(input logic rd, input logic [7:0] a,
                       input logic [15:0] d);
        avsAddress <= a;
        avsWriteData <= {16'h0, d};
        avsRead <= rd;
        avsWrite <= !rd;
        do
            @(posedge clk);
        while (avsWaitRequest !== 1'b0);
        q = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge clk);
    endtask

    // s: edge after which the select fell, e: edge after which done rose
    task automatic cyc(input logic [23:0] a, input logic [2:0] fc,
                       input int ds);
        addr <= a;
        funcCode <= fc;
        addrStrobe <= 1'b1;
        dataStrobe <= (ds == 0);
        s = -1;
        e = -1;
        for (int k = 0; k < 40 && e < 0; k++)
        begin
            @(posedge clk);
            dataStrobe <= (k + 1 >= ds);
            @(negedge clk);
            if (s < 0 && selN[idx] === 1'b0)
                s = k;
            if (cycleDone === 1'b1)
            begin
                e = k;
                chk("ack enable", avReq ? 2'h3 : 2'h0, oeN);
            end
        end
        @(posedge clk);
        @(negedge clk);
        av = avReq;
        if (e >= 0)
            chk("select after done", 1'b1, selN[idx]);
        chk("boot pin", selN[0], bootN);
        chk("ack pins", 0, ackOutN);
        @(posedge clk);
        addrStrobe <= 1'b0;
        dataStrobe <= 1'b0;
        // the synchronised ack pins take a few cycles to release
        repeat (5) @(posedge clk);
    endtask

    function automatic int hitExp(logic [3:0] t, logic u, logic l, logic r);
        return ((t[3] & u) | (t[2] & l)) & (r ? t[0] : t[1]);
    endfunction

    // ==========================================================
    // main sequence
    initial
    begin
        void'($urandom(61));
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        bus(1'b1, OPT_OFFSET, 16'h0);
        chk("boot options", BOOT_OPT_RESET, q);
        bus(1'b1, BASE_OFFSET, 16'h0);
        chk("boot base", BOOT_BASE_RESET, q);
        bus(1'b1, 8'hC0, 16'h0);
        chk("unmapped read", 32'h0, q);
        cyc(24'h0FFFFE, 3'h6, 0);
        chk("boot waits", 13, e);
        cyc(24'h100000, 3'h6, 0);
        chk("outside range", -1, s);
        for (int i = 3; i < NUM_SEL; i++)
        begin
            n = $urandom;
            bus(1'b0, OPT_OFFSET + 8'(4 * i), 16'(n));
            bus(1'b1, OPT_OFFSET + 8'(4 * i), 16'h0);
            chk("option readback", {16'h0, 16'(n)}, q);
        end
        idx = 1;
        bus(1'b0, BASE_OFFSET + 8'h04, 16'h3003);
        for (int t = 0; t < 16; t++)
        begin
            bus(1'b0, OPT_OFFSET + 8'h04, {1'b0, 4'(t), 11'h070});
            upperLane <= 1'($urandom);
            n = $urandom;
            lowerLane <= n[0] | !upperLane;
            isRead <= n[1];
            @(posedge clk);
            n = hitExp(4'(t), upperLane, lowerLane, isRead);
            cyc(24'h30FFF0, 3'h5, 0);
            chk("lane and direction", n ? 1 : -1, e);
        end
        isRead <= 1'b1;
        upperLane <= 1'b1;
        lowerLane <= 1'b1;
        for (int j = 0; j < 4; j++)
        begin
            n = (j == 0) ? 1 : (j == 1) ? 1 + $urandom % 13 : 11 + j;
            bus(1'b0, OPT_OFFSET + 8'h04, 16'h7830 | 16'(n << 6));
            cyc(24'h300000, 3'h2, 0);
            chk("wait count", n == 14 ? 0 : n, e);
        end
        bus(1'b0, OPT_OFFSET + 8'h04, 16'h7F70);
        cyc(24'h300000, 3'h1, 3);
        chk("data strobe timing", 3, s);
        bus(1'b0, OPT_OFFSET + 8'h04, 16'h7BF0);
        cyc(24'h300000, 3'h1, 0);
        chk("no external ack", -1, e);
        ackOn <= 1'b1;
        cyc(24'h300000, 3'h1, 0);
        chk("external ack", 1, e > 1 && e < 12);
        bus(1'b0, OPT_OFFSET + 8'h04, 16'h7B70);
        cyc(24'h300000, 3'h1, 0);
        chk("ack before count", 1, e > 1 && e < 13);
        ackOn <= 1'b0;
        bus(1'b0, OPT_OFFSET + 8'h04, 16'hFFF0);
        cyc(24'h300000, 3'h1, 0);
        chk("sync mode", 1, e >= 0 && e < 12);
        @(posedge slow);
        n = cycles;
        @(posedge slow);
        chk("slow clock period", 8, cycles - n);
        idx = 2;
        bus(1'b0, BASE_OFFSET + 8'h08, 16'hFFF8);
        for (int j = 0; j < 3; j++)
        begin
            n = $urandom % 8;
            // read-only, address-strobe timing, cpu space for these cycles
            bus(1'b0, OPT_OFFSET + 8'h08, 16'h6B40 | 16'(n << 1) | 16'(j != 2));
            cyc(24'hFFFFF0 | 24'((n ^ (j == 1)) << 1), FC_CPU, 0);
            chk("int_ack_out done", j == 1 ? -1 : j == 2 ? 13 : 0, e);
            chk("autovector", j == 0, av);
        end
        bus(1'b0, BASE_OFFSET + 8'h0C, 16'h3003);
        bus(1'b0, OPT_OFFSET + 8'h0C, 16'h3870);
        bus(1'b0, OPT_OFFSET + 8'h04, 16'h5870);
        for (int j = 0; j < 2; j++)
        begin
            idx = j ? 3 : 1;
            upperLane <= !j;
            lowerLane <= j[0];
            cyc(24'h300000, 3'h5, 0);
            chk("twin lane", 0, s);
        end
        complete_run();
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            complete_run();
        end
    end
endmodule
